//--- hdl/tdmrf_pkg.sv
/*
  Constants, register map and carrier types of the TDM port rate and
  frame timing block.
  Assumes a 200 MHz APB clock and an 8.192 MHz master input clock.
*/
`default_nettype none
package tdmrf_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LIR_OFS  = 8'h04;
  localparam logic [7:0] LOR_OFS  = 8'h08;
  localparam logic [7:0] BIR_OFS  = 8'h0C;
  localparam logic [7:0] BOR_OFS  = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam logic [31:0] RATE_RST = 32'h0000_0000;
  localparam int CM_MSG_BIT = 15;
  localparam int CM_EN_BIT  = 14;
  localparam int CM_SRC_BIT = 13;
  localparam int HALF_STREAMS = 8;
  localparam int PCLK_KHZ    = 200000;
  localparam int INT_CLK_KHZ = 131072;
  localparam int FP_SINGLE_NS = 122;
  localparam int FRAME_US     = 125;
  localparam int FP8_TICKS_I =
    (FP_SINGLE_NS * INT_CLK_KHZ + 999999) / 1000000;
  localparam logic [13:0] FP8_TICKS  = 14'(FP8_TICKS_I);
  localparam logic [13:0] FP16_TICKS = 14'(FP8_TICKS_I / 2);
  localparam logic [13:0] FRAME_LAST = 14'(FRAME_US * INT_CLK_KHZ / 1000 - 1);
  localparam logic [18:0] NCO_INC = 19'(INT_CLK_KHZ);
  localparam logic [18:0] NCO_MOD = 19'(PCLK_KHZ);
  localparam logic [7:0]  STYLE_RUN = 8'h20;
  localparam logic [1:0]  FRAME_DELAY = 2'h2;

  typedef struct packed {
    logic output_clock_polarity_sel;
    logic clk_edge;
    logic frame_pulse_width_sel;
    logic b32;
    logic l32;
  } tdmrf_ctrl_t;
  localparam tdmrf_ctrl_t CTRL_RST = '0;

  typedef enum logic [2:0] {
    RATE_UNUSED, RATE_2M, RATE_4M, RATE_8M, RATE_16M, RATE_32M
  } tdmrf_rate_t;
  typedef tdmrf_rate_t [15:0] tdmrf_port_rates_t;

  typedef struct packed {
    tdmrf_port_rates_t l_in;
    tdmrf_port_rates_t l_out;
    tdmrf_port_rates_t b_in;
    tdmrf_port_rates_t b_out;
  } tdmrf_rates_t;

  typedef struct packed {
    logic msg_mode;
    logic out_en;
    logic src_bp;
  } tdmrf_cm_t;

  typedef struct packed {
    logic [13:0] tick;
    logic [1:0]  in_frame;
    logic [1:0]  out_frame;
    logic        frame_start;
    logic        gci;
  } tdmrf_timing_t;
endpackage : tdmrf_pkg
`default_nettype wire

//--- hdl/tdmrf_top.sv
/*
  TDM port rate and frame timing: APB registers, master frame pulse and
  clock capture, style detection, generated frame pulses and clocks.
  Assumes master pulse and clock are asynchronous to pclk.
*/
// Operation
// - local high rate bit selects 32 Mbps
// - backplane high rate bit selects 32 Mbps
// - reset clears both high rate bits
// - port rates use only own settings
// - per-stream field picks one of four rates
// - local 32 mode: streams 0-7 fixed
// - backplane 32 mode: streams 0-7 fixed
// - inputs align to master pulse, clock
// - outputs align to generated pulse, clock
// - connection word gives mode, enable, source
// - detect telecom or GCI pulse style
// - output pulses follow detected style
// - edge bit picks input clock edge
// - make 8/16 MHz pulses, clocks, polarity
// - stream timing from 131.072 MHz tick
// - frame N data leaves in N+2
// - width bit doubles generated pulses only
// - high rate mode ignores rate registers
`timescale 1ns/1ps
`default_nettype none
module tdmrf_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    master_frame_pulse_in,
  input  wire logic                    master_clock_in,
  input  wire logic [15:0]             local_cm_word,
  input  wire logic [15:0]             backplane_cm_word,
  output tdmrf_pkg::tdmrf_cm_t         local_cm_ctrl,
  output tdmrf_pkg::tdmrf_cm_t         backplane_cm_ctrl,
  output logic                         frame_pulse_out_8m,
  output logic                         frame_pulse_out_16m,
  output logic                         clock_out_8m,
  output logic                         clock_out_16m,
  output tdmrf_pkg::tdmrf_rates_t      stream_rates,
  output tdmrf_pkg::tdmrf_timing_t     stream_timing
);
  import tdmrf_pkg::*;

  function automatic tdmrf_port_rates_t port_rates(
    input logic        hi_mode,
    input logic [31:0] fields
  );
    tdmrf_port_rates_t r;
    r = '{default: RATE_UNUSED};
    for (int i = 0; i < 16; i++)
    begin
      if (hi_mode)
        r[i] = (i < HALF_STREAMS) ? RATE_32M : RATE_UNUSED;
      else
        case (fields[2*i +: 2])
          2'h0: r[i] = RATE_2M;
          2'h1: r[i] = RATE_4M;
          2'h2: r[i] = RATE_8M;
          default: r[i] = RATE_16M;
        endcase
    end
    return r;
  endfunction : port_rates

  function automatic tdmrf_cm_t cm_decode(input logic [15:0] w);
    return '{msg_mode: w[CM_MSG_BIT], out_en: w[CM_EN_BIT],
             src_bp: w[CM_SRC_BIT]};
  endfunction : cm_decode

  tdmrf_ctrl_t   ctrl_q;
  logic [31:0]   lir_q;
  logic [31:0]   lor_q;
  logic [31:0]   bir_q;
  logic [31:0]   bor_q;
  logic [31:0]   prdata_q;
  logic          clk_s1_q;
  logic          clk_s2_q;
  logic          clk_s3_q;
  logic          fp_s1_q;
  logic          fp_s2_q;
  logic          fp_smp_q;
  logic [7:0]    run_q;
  logic          gci_q;
  logic [18:0]   acc_q;
  logic [13:0]   tick_q;
  logic [1:0]    in_frame_q;
  logic          fs_q;
  logic          fp8_q;
  logic          fp16_q;
  logic          c8_q;
  logic          c16_q;
  tdmrf_rates_t  rates_q;
  tdmrf_cm_t     lcm_q;
  tdmrf_cm_t     bcm_q;

  // APB decode; no wait states, unmapped gives slave error
  wire sel_ctrl = (paddr == CTRL_OFS);
  wire sel_lir  = (paddr == LIR_OFS);
  wire sel_lor  = (paddr == LOR_OFS);
  wire sel_bir  = (paddr == BIR_OFS);
  wire sel_bor  = (paddr == BOR_OFS);
  wire sel_stat = (paddr == STAT_OFS);
  wire addr_ok  = sel_ctrl | sel_lir | sel_lor | sel_bir | sel_bor | sel_stat;
  wire setup_rd = psel & ~penable & ~pwrite;
  wire wr_en    = psel & penable & pwrite & addr_ok;
  wire [1:0] out_frame = in_frame_q - FRAME_DELAY;
  wire [31:0] stat_word = {13'h0000, gci_q, in_frame_q, out_frame, tick_q};
  wire [31:0] rd_data =
    sel_ctrl ? {27'h0000000, ctrl_q} :
    sel_lir  ? lir_q :
    sel_lor  ? lor_q :
    sel_bir  ? bir_q :
    sel_bor  ? bor_q :
    sel_stat ? stat_word : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata  = prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= CTRL_RST;
      lir_q    <= RATE_RST;
      lor_q    <= RATE_RST;
      bir_q    <= RATE_RST;
      bor_q    <= RATE_RST;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      if (wr_en && sel_ctrl)
        ctrl_q <= tdmrf_ctrl_t'(pwdata[4:0]);
      if (wr_en && sel_lir)
        lir_q <= pwdata;
      if (wr_en && sel_lor)
        lor_q <= pwdata;
      if (wr_en && sel_bir)
        bir_q <= pwdata;
      if (wr_en && sel_bor)
        bor_q <= pwdata;
      if (setup_rd)
        prdata_q <= rd_data;
    end
  end

  // Each port looks only at its own mode bit and fields
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rates_q <= {4{port_rates(1'b0, RATE_RST)}};
    else
    begin
      rates_q.l_in  <= port_rates(ctrl_q.l32, lir_q);
      rates_q.l_out <= port_rates(ctrl_q.l32, lor_q);
      rates_q.b_in  <= port_rates(ctrl_q.b32, bir_q);
      rates_q.b_out <= port_rates(ctrl_q.b32, bor_q);
    end
  end

  // Two-stage capture; stage 3 only feeds edge detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      fp_s1_q  <= 1'b1;
      fp_s2_q  <= 1'b1;
    end
    else
    begin
      clk_s1_q <= master_clock_in;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      fp_s1_q  <= master_frame_pulse_in;
      fp_s2_q  <= fp_s1_q;
    end
  end

  wire rise_edge = clk_s2_q & ~clk_s3_q;
  wire fall_edge = ~clk_s2_q & clk_s3_q;
  wire act_edge  = ctrl_q.clk_edge ? rise_edge : fall_edge;
  // Leading active sample of the pulse marks the frame boundary
  wire frame_start = act_edge & (fp_s2_q == gci_q)
                   & (fp_smp_q != gci_q);
  wire [18:0] acc_sum = acc_q + NCO_INC;
  wire        nco_tick = (acc_sum >= NCO_MOD);
  wire [13:0] fp8_len  = ctrl_q.frame_pulse_width_sel ? {FP8_TICKS[12:0], 1'b0} : FP8_TICKS;
  wire [13:0] fp16_len = ctrl_q.frame_pulse_width_sel ? FP8_TICKS : FP16_TICKS;

  // Idle level held for a long run reveals the pulse style
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fp_smp_q <= 1'b1;
      run_q    <= 8'h00;
      gci_q    <= 1'b0;
    end
    else if (act_edge)
    begin
      fp_smp_q <= fp_s2_q;
      if (fp_s2_q != fp_smp_q)
        run_q <= 8'h00;
      else if (run_q != STYLE_RUN)
        run_q <= run_q + 8'h01;
      if (run_q == STYLE_RUN)
        gci_q <= ~fp_smp_q;
    end
  end

  // Fractional tick: average 131.072 MHz out of 200 MHz
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q      <= 19'h00000;
      tick_q     <= 14'h0000;
      in_frame_q <= 2'h0;
      fs_q       <= 1'b0;
    end
    else
    begin
      fs_q <= frame_start;
      if (frame_start)
      begin
        acc_q      <= 19'h00000;
        tick_q     <= 14'h0000;
        in_frame_q <= in_frame_q + 2'h1;
      end
      else
      begin
        acc_q <= nco_tick ? acc_sum - NCO_MOD : acc_sum;
        if (nco_tick && tick_q != FRAME_LAST)
          tick_q <= tick_q + 14'h0001;
      end
    end
  end

  // Pulses active low for telecom style, high for GCI style
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fp8_q  <= 1'b1;
      fp16_q <= 1'b1;
      c8_q   <= 1'b0;
      c16_q  <= 1'b0;
      lcm_q  <= '0;
      bcm_q  <= '0;
    end
    else
    begin
      fp8_q  <= (tick_q < fp8_len) ^ ~gci_q;
      fp16_q <= (tick_q < fp16_len) ^ ~gci_q;
      c8_q   <= tick_q[3] ^ ctrl_q.output_clock_polarity_sel;
      c16_q  <= tick_q[2] ^ ctrl_q.output_clock_polarity_sel;
      lcm_q  <= cm_decode(local_cm_word);
      bcm_q  <= cm_decode(backplane_cm_word);
    end
  end

  assign local_cm_ctrl       = lcm_q;
  assign backplane_cm_ctrl   = bcm_q;
  assign frame_pulse_out_8m  = fp8_q;
  assign frame_pulse_out_16m = fp16_q;
  assign clock_out_8m        = c8_q;
  assign clock_out_16m       = c16_q;
  assign stream_rates        = rates_q;
  assign stream_timing = '{tick: tick_q, in_frame: in_frame_q,
                           out_frame: out_frame, frame_start: fs_q,
                           gci: gci_q};

  AST_RESET_MODES: assert property (@(posedge pclk)
    $rose(presetn) |-> !ctrl_q.l32 && !ctrl_q.b32)
    else $error("high rate bits not clear after reset");
  AST_LOCAL_HIGH: assert property (@(posedge pclk)
    disable iff (!presetn)
    ctrl_q.l32 |=> stream_rates.l_in[0] == RATE_32M
                && stream_rates.l_out[8] == RATE_UNUSED)
    else $error("local high rate stream map wrong");
  AST_BP_HIGH: assert property (@(posedge pclk)
    disable iff (!presetn)
    ctrl_q.b32 |=> stream_rates.b_out[7] == RATE_32M
                && stream_rates.b_in[15] == RATE_UNUSED)
    else $error("backplane high rate stream map wrong");
  AST_FIELD_RATE: assert property (@(posedge pclk)
    disable iff (!presetn)
    !ctrl_q.l32 && lir_q[5:4] == 2'h2 |=> stream_rates.l_in[2] == RATE_8M)
    else $error("rate field decode wrong");
  AST_PORT_INDEP: assert property (@(posedge pclk)
    disable iff (!presetn)
    $stable(ctrl_q.l32) && $stable(lir_q) && $changed(ctrl_q.b32)
    |=> $stable(stream_rates.l_in))
    else $error("local rates moved with backplane mode");
  AST_THRU_DELAY: assert property (@(posedge pclk)
    disable iff (!presetn)
    frame_start |=> stream_timing.in_frame == $past(in_frame_q) + 2'h1
                    && stream_timing.out_frame
                       == $past(in_frame_q) + 2'h1 - FRAME_DELAY)
    else $error("output frame not two behind input");
  AST_ALIGN: assert property (@(posedge pclk)
    disable iff (!presetn)
    frame_start |=> tick_q == 14'h0000 ##1 fp8_q == gci_q)
    else $error("output frame not aligned to boundary");
  AST_EDGE: assert property (@(posedge pclk)
    disable iff (!presetn)
    frame_start |-> (ctrl_q.clk_edge ? $rose(clk_s2_q) : $fell(clk_s2_q)))
    else $error("boundary taken on wrong clock edge");
  AST_STYLE_IDLE: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick_q > {FP8_TICKS[12:0], 1'b0} && $stable(gci_q)
    |=> fp8_q == ~$past(gci_q) && fp16_q == ~$past(gci_q))
    else $error("output pulse idle level wrong for style");
  AST_DOUBLE: assert property (@(posedge pclk)
    disable iff (!presetn)
    ctrl_q.frame_pulse_width_sel && tick_q == FP8_TICKS |=> fp8_q == $past(gci_q))
    else $error("double width pulse too short");
  AST_CM: assert property (@(posedge pclk)
    disable iff (!presetn)
    1'b1 |=> local_cm_ctrl.out_en == $past(local_cm_word[CM_EN_BIT])
         && backplane_cm_ctrl.src_bp == $past(backplane_cm_word[CM_SRC_BIT]))
    else $error("connection word decode wrong");
endmodule : tdmrf_top
`default_nettype wire

//--- dv/tdmrf_src_model.sv
/* Master frame pulse and master clock source for the tdmrf bench.
   Assumes style and width inputs are changed between frames only. */
`timescale 1ns/1ps
`default_nettype none
module tdmrf_src_model #(
  parameter int FRAME_CLKS = 781
) (
  input  wire logic gci,
  input  wire logic wide,
  output logic      mclk,
  output logic      mfp
);
  int cnt = 0;
  initial
  begin
    mclk = 1'b0;
    forever #80 mclk = ~mclk;
  end
  // Update on the inactive edge so the active edge sees a steady level
  always @(mclk)
  begin
    if (mclk != gci)
    begin
      cnt <= (cnt == FRAME_CLKS - 1) ? 0 : cnt + 1;
      mfp <= (cnt < (wide ? 2 : 1)) ? gci : ~gci;
    end
  end
endmodule : tdmrf_src_model
`default_nettype wire

//--- dv/tdmrf_top_tb_top.sv
/* Self-checking bench of the tdmrf block: registers, rates, cm words,
   frame pulses. Assumes the source model gives short frames. */
`timescale 1ns/1ps
`default_nettype none
module tdmrf_top_tb_top;
  import tdmrf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic er, gci, wide, mclk, mfp, fp8, fp16, c8, c16;
  logic [15:0] lw, bw;
  tdmrf_cm_t     lcm, bcm;
  tdmrf_rates_t  sr;
  tdmrf_timing_t tm;
  int fails = 0;
  int check_count = 0;
  int cyc = 0;
  tdmrf_top i_tdmrf_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_frame_pulse_in(mfp), .master_clock_in(mclk),
    .local_cm_word(lw), .backplane_cm_word(bw), .local_cm_ctrl(lcm),
    .backplane_cm_ctrl(bcm), .frame_pulse_out_8m(fp8),
    .frame_pulse_out_16m(fp16), .clock_out_8m(c8),
    .clock_out_16m(c16), .stream_rates(sr), .stream_timing(tm));
  // Short frames keep the run small
  tdmrf_src_model #(.FRAME_CLKS(200)) i_tdmrf_src_model (.gci(gci),
    .wide(wide), .mclk(mclk), .mfp(mfp));
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Waits as long as the slave asks; only the bench timeout ends it
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic tdmrf_rate_t er_(logic hi, logic [31:0] r, int i);
    if (hi)
      return (i < HALF_STREAMS) ? RATE_32M : RATE_UNUSED;
    return tdmrf_rate_t'(3'(r[2*i+:2]) + 3'h1);
  endfunction : er_
  task automatic chk_rates(input logic lh, bh,
                           input logic [31:0] li, lo, bi, bo);
    repeat (3) @(negedge pclk);
    for (int i = 0; i < 16; i++)
    begin
      check(sr.l_in[i] === er_(lh, li, i), "l_in");
      check(sr.l_out[i] === er_(lh, lo, i), "l_out");
      check(sr.b_in[i] === er_(bh, bi, i), "b_in");
      check(sr.b_out[i] === er_(bh, bo, i), "b_out");
    end
  endtask : chk_rates
  task automatic t_regs;
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rdv === 32'h0000_0000, "ctrl reset");
    chk_rates(0, 0, 0, 0, 0, 0);
    apb(1'b1, LIR_OFS, 32'hE4E4_E4E4);
    apb(1'b1, BOR_OFS, 32'h1B1B_1B1B);
    chk_rates(0, 0, 32'hE4E4_E4E4, 0, 0, 32'h1B1B_1B1B);
    apb(1'b1, CTRL_OFS, 32'h01);
    chk_rates(1, 0, 0, 0, 0, 32'h1B1B_1B1B);
    apb(1'b1, CTRL_OFS, 32'h02);
    chk_rates(0, 1, 32'hE4E4_E4E4, 0, 0, 0);
    apb(1'b0, 8'h18, 32'h0);
    check(er === 1'b1 && rdv === 32'h0, "unmapped read");
    apb(1'b1, 8'h18, 32'h1F);
    apb(1'b0, CTRL_OFS, 32'h0);
    check(rdv === 32'h0000_0002, "ctrl after bad write");
  endtask : t_regs
  task automatic t_cm;
    for (int v = 0; v < 8; v++)
    begin
      @(posedge pclk);
      lw <= {3'(v), 13'h0};
      bw <= {3'(~v), 13'h1FFF};
      repeat (2) @(negedge pclk);
      check(lcm === 3'(v) && bcm === 3'(~v), "cm word");
    end
  endtask : t_cm
  task automatic t_frame(input logic g, w, cp);
    int n, w8, w16, m;
    logic [1:0] p;
    m = w ? 2 : 1;
    @(posedge pclk);
    gci <= g;
    wide <= w;
    apb(1'b1, CTRL_OFS, {27'h0, cp, g, w, 2'h0});
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      @(negedge pclk);
      while (fp8 !== ~g && n < 9000)
      begin
        n++;
        @(negedge pclk);
      end
      while (fp8 !== g && n < 18000)
      begin
        n++;
        @(negedge pclk);
      end
      check(n < 18000, "no output frame pulse");
      // Style switch may add a stray pulse early; last two are real
      if (k == 1)
        p = tm.in_frame;
    end
    check(tm.gci === g, "style");
    check(c8 === cp, "clock polarity at boundary");
    check(c16 === cp, "16m clock polarity at boundary");
    check(tm.tick <= 14'h0002, "tick not restarted at boundary");
    check(tm.in_frame === p + 2'h1, "frame count");
    check(tm.out_frame === p + 2'h1 - FRAME_DELAY, "delay");
    w8 = 0;
    w16 = 0;
    while (w8 < 200 && (fp8 === g || fp16 === g))
    begin
      w8 += (fp8 === g);
      w16 += (fp16 === g);
      @(negedge pclk);
    end
    n = 16 * m * 25000 / 16384;
    check(w8 >= n - 2 && w8 <= n + 2, "fp8 width");
    n = n / 2;
    check(w16 >= n - 3 && w16 <= n + 3, "fp16 width");
  endtask : t_frame
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 95000)
    begin
      fails++;
      complete_run();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {lw, bw, gci, wide} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cm();
    t_frame(1'b0, 1'b0, 1'b0);
    t_frame(1'b0, 1'b1, 1'b1);
    t_frame(1'b1, 1'b0, 1'b0);
    complete_run();
  end
endmodule : tdmrf_top_tb_top
`default_nettype wire
